// >>> rtl/mro_host.sv
// Host capture end: drives master clock, reset, sync and latches words
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module mro_host #(
  parameter int unsigned MCLK_HALF  = mro_pkg::MCLK_HALF_DEF,
  parameter int unsigned LINK_DELAY = mro_pkg::LINK_DELAY_DEF
) (
  // Clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_SYS_RST,
  // Link to converter
  mro_link_if.host                           LINK,
  // Register port
  input  wire logic [mro_pkg::ADDR_W-1:0]    I_ADDR,
  input  wire logic [mro_pkg::DATA_W-1:0]    I_WDATA,
  input  wire logic                          I_WR,
  input  wire logic                          I_RD,
  output logic      [mro_pkg::DATA_W-1:0]    O_RDATA,
  // Captured words
  output logic      [mro_pkg::WORD_W-1:0]    O_WORD,
  output logic                               O_WORD_VALID,
  output logic                               O_PARITY_ODD
);
  import mro_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0]      div;
    logic                  mclk;
    logic [CTRL_W-1:0]     ctrl;
    logic                  pend_rst;
    logic                  pend_sync;
    mro_seq_t              seq;
    logic [LOW_CNT_W-1:0]  low_cnt;
    logic                  counting;
    logic                  odd;
    logic                  parity_valid;
    logic                  strobe_prev;
    logic [LINK_DELAY-1:0] fall_pipe;
    logic [WORD_W-1:0]     word;
    logic                  word_valid;
    logic [COUNT_W-1:0]    count;
    logic [DATA_W-1:0]     rdata;
  } mro_host_state_t;

  mro_host_state_t q;
  mro_host_state_t d;

  logic [HOST_IN_W-1:0] pins_s;
  logic                 s_strobe_n;
  logic [WORD_W-1:0]    s_data;
  logic                 tick;
  logic                 mclk_rise;
  logic                 mclk_fall;
  logic                 odd_mode;
  logic                 take;
  logic [LOW_CNT_W-1:0] low_next;

  mro_sync #(
    .W       (HOST_IN_W),
    .RST_VAL (HOST_IN_RST)
  ) u_pin_sync (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .i_d   ({LINK.word_ready_strobe_n, LINK.data}),
    .o_q   (pins_s)
  );

  assign {s_strobe_n, s_data} = pins_s;

  // Master clock from a divider; edges are enables, not clocks
  assign tick      = (q.div == DIV_W'(MCLK_HALF - 1));
  assign mclk_rise = tick & ~q.mclk;
  assign mclk_fall = tick & q.mclk;
  assign low_next  = LOW_CNT_W'(q.low_cnt + 4'h1);

  // Odd parity with half rate: sample on a delayed fall while strobe low
  assign odd_mode = ~q.ctrl[CTRL_CLOCK_DIVIDER_SELECT_BIT] & q.parity_valid & q.odd;
  assign take     = q.ctrl[CTRL_CAPTURE_BIT] &
                    (odd_mode ? (q.fall_pipe[LINK_DELAY-1] & ~s_strobe_n)
                              : (s_strobe_n & ~q.strobe_prev));

  always_comb begin
    d             = q;
    d.word_valid  = 1'b0;
    d.rdata       = '0;
    d.div         = tick ? '0 : DIV_W'(q.div + 8'h01);
    d.mclk        = tick ? ~q.mclk : q.mclk;
    // Fall delay matches the round trip through both synchronisers
    d.fall_pipe   = {q.fall_pipe[LINK_DELAY-2:0], mclk_fall};
    d.strobe_prev = s_strobe_n;
    if (mclk_rise && q.counting) begin
      d.odd = ~q.odd;
    end
    case (q.seq)
      SEQ_IDLE: begin
        if (mclk_rise && q.pend_rst) begin
          d.seq          = SEQ_RESET_LOW;
          d.pend_rst     = 1'b0;
          d.low_cnt      = '0;
          d.counting     = 1'b0;
          d.parity_valid = 1'b0;
        end else if (mclk_rise && q.pend_sync) begin
          d.seq       = SEQ_SYNC_LOW;
          d.pend_sync = 1'b0;
          d.low_cnt   = '0;
        end
      end
      SEQ_RESET_LOW: begin
        if (mclk_rise) begin
          d.low_cnt = low_next;
          if (low_next == RESET_LOW_MCLK) begin
            d.seq      = SEQ_IDLE;
            d.counting = 1'b1;
            d.odd      = 1'b0;
          end
        end
      end
      SEQ_SYNC_LOW: begin
        if (mclk_rise) begin
          d.low_cnt = low_next;
          if (low_next == SYNC_LOW_MCLK) begin
            d.seq = SEQ_IDLE;
            if (q.counting) begin
              d.counting     = 1'b0;
              d.parity_valid = 1'b1;
            end
          end
        end
      end
      default: begin
        d.seq = SEQ_IDLE;
      end
    endcase
    if (take) begin
      d.word       = s_data;
      d.word_valid = 1'b1;
      d.count      = COUNT_W'(q.count + 16'h0001);
    end
    // Writes come last so a new command beats a same-cycle clear
    if (I_WR) begin
      case (I_ADDR)
        REG_CTRL: d.ctrl = I_WDATA[CTRL_W-1:0];
        REG_CMD: begin
          d.pend_rst  = d.pend_rst | I_WDATA[CMD_RESET_BIT];
          d.pend_sync = d.pend_sync | I_WDATA[CMD_SYNC_BIT];
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (I_RD) begin
      case (I_ADDR)
        REG_CTRL:   d.rdata = DATA_W'(q.ctrl);
        REG_STATUS: begin
          d.rdata[ST_ODD_BIT]                       = q.odd;
          d.rdata[ST_VALID_BIT]                     = q.parity_valid;
          d.rdata[ST_BUSY_BIT]                      = (q.seq != SEQ_IDLE) | q.pend_rst
                                                      | q.pend_sync;
          d.rdata[ST_COUNT_LSB +: COUNT_W]          = q.count;
        end
        REG_DATA:   d.rdata = DATA_W'(q.word);
        default:    d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q      <= '0;
      q.ctrl <= CTRL_RST;
      q.seq  <= SEQ_IDLE;
      // Idle strobe level, so no false rise follows reset
      q.strobe_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Link outputs
  assign LINK.mclk                 = q.mclk;
  assign LINK.reset_n              = (q.seq != SEQ_RESET_LOW);
  assign LINK.sync_n               = (q.seq != SEQ_SYNC_LOW);
  assign LINK.rd_wr_n              = ~q.ctrl[CTRL_CAPTURE_BIT];
  assign LINK.cs_n                 = ~q.ctrl[CTRL_CAPTURE_BIT];
  assign LINK.first_filter_bypass  = q.ctrl[CTRL_F1_BIT];
  assign LINK.third_filter_bypass  = q.ctrl[CTRL_F3_BIT];
  assign LINK.clock_divider_select = q.ctrl[CTRL_CLOCK_DIVIDER_SELECT_BIT];
  assign LINK.decimation_select    = q.ctrl[CTRL_DEC_LSB +: DEC_W];

  // User outputs
  assign O_RDATA      = q.rdata;
  assign O_WORD       = q.word;
  assign O_WORD_VALID = q.word_valid;
  assign O_PARITY_ODD = q.odd;
endmodule

// >>> rtl/mro_pkg.sv
// Shared constants and types for the raw modulator output link
package mro_pkg;

  // Clock
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 20;

  // Word layout
  localparam int unsigned WORD_W           = 16;
  localparam int unsigned CODE_W           = 15;
  localparam int unsigned ZERO_LSBS        = 4;
  localparam int unsigned DEC_W            = 3;
  localparam logic [2:0]  DEC_MOD_MODE     = 3'h0;

  // Host register port
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 32;
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_CMD          = 4'h4;
  localparam logic [3:0]  REG_STATUS       = 4'h8;
  localparam logic [3:0]  REG_DATA         = 4'hC;

  // Host control register fields
  localparam int unsigned CTRL_W           = 7;
  localparam int unsigned CTRL_CAPTURE_BIT = 0;
  localparam int unsigned CTRL_CLOCK_DIVIDER_SELECT_BIT    = 1;
  localparam int unsigned CTRL_F1_BIT      = 2;
  localparam int unsigned CTRL_F3_BIT      = 3;
  localparam int unsigned CTRL_DEC_LSB     = 4;
  localparam logic [6:0]  CTRL_RST         = 7'h0E;

  // Host command register fields
  localparam int unsigned CMD_RESET_BIT    = 0;
  localparam int unsigned CMD_SYNC_BIT     = 1;

  // Host status register fields
  localparam int unsigned ST_ODD_BIT       = 0;
  localparam int unsigned ST_VALID_BIT     = 1;
  localparam int unsigned ST_BUSY_BIT      = 2;
  localparam int unsigned ST_COUNT_LSB     = 16;
  localparam int unsigned COUNT_W          = 16;

  // Link timing, in master clock cycles and system cycles
  localparam int unsigned LOW_CNT_W        = 4;
  localparam logic [3:0]  RESET_LOW_MCLK   = 4'h1;
  localparam logic [3:0]  SYNC_LOW_MCLK    = 4'h4;
  localparam int unsigned DIV_W            = 8;
  localparam int unsigned MCLK_HALF_DEF    = 4;
  localparam int unsigned LINK_DELAY_DEF   = 5;

  // Synchroniser widths and reset values
  localparam int unsigned DEV_IN_W         = 11;
  localparam logic [10:0] DEV_IN_RST       = 11'h1F8;
  localparam int unsigned HOST_IN_W        = 17;
  localparam logic [16:0] HOST_IN_RST      = 17'h1FFFF;

  // Host reset and sync sequencer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RESET_LOW, SEQ_SYNC_LOW} mro_seq_t;

endpackage

// >>> rtl/mro_link_if.sv
// Pin-level link between the converter end and the host capture end
`timescale 1ns/1ps
interface mro_link_if;
  logic                        mclk;
  logic                        reset_n;
  logic                        sync_n;
  logic                        rd_wr_n;
  logic                        cs_n;
  logic                        first_filter_bypass;
  logic                        third_filter_bypass;
  logic                        clock_divider_select;
  logic [mro_pkg::DEC_W-1:0]   decimation_select;
  logic                        word_ready_strobe_n;
  logic [mro_pkg::WORD_W-1:0]  data_out;
  logic                        data_oe_n;
  logic [mro_pkg::WORD_W-1:0]  data;

  // Released bus reads as pulled high
  assign data = data_oe_n ? 16'hFFFF : data_out;

  modport device (
    input  mclk, reset_n, sync_n, rd_wr_n, cs_n,
    input  first_filter_bypass, third_filter_bypass, clock_divider_select, decimation_select,
    output word_ready_strobe_n, data_out, data_oe_n
  );

  modport host (
    output mclk, reset_n, sync_n, rd_wr_n, cs_n,
    output first_filter_bypass, third_filter_bypass, clock_divider_select, decimation_select,
    input  word_ready_strobe_n, data
  );
endinterface

// >>> rtl/mro_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mro_sync #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Data
  input  wire logic [W-1:0]  i_d,
  output logic      [W-1:0]  o_q
);
  import mro_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mro_sync_state_t;

  mro_sync_state_t q;
  mro_sync_state_t d;

  // First stage feeds only the second
  always_comb begin
    d        = q;
    d.meta   = i_d;
    d.stable = q.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign o_q = q.stable;
endmodule

// >>> rtl/mro_device.sv
// Converter end: raw modulator words onto the parallel link
// What this block does
// - Modulator mode bypasses all filtering and decimation
// - Host enters mode writing zero bypass, decimation
// - Word is 16-bit twos complement, 15-bit scale
// - Four lowest data bits always driven zero
// - Word rate: master clock, or half when divider low
// - Host holds read/write and select low throughout
// - Divider high: one strobe per word, valid at rise
// - Bus released after read/write and select go high
// - Divider low: strobe toggles at half master clock
// - Host capture timing follows reset-to-sync cycle parity
// - Odd parity: data updates at strobe rising edge
// - Odd parity: host samples master clock fall, strobe low
// - Sync sampled on falls, holds sequencer; four cycles low
// - Offset, gain, overrange idle in modulator mode
`timescale 1ns/1ps
module mro_device (
  // Clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_SYS_RST,
  // Link to host
  mro_link_if.device                         LINK,
  // Modulator code from the analog core
  input  wire logic signed [mro_pkg::CODE_W-1:0] I_MOD_CODE,
  // Status
  output logic                               O_MOD_MODE,
  output logic                               O_SEQ_RESET,
  output logic                               O_CORRECTION_ENABLE,
  output logic                               O_CODE_TAKEN,
  output logic                               O_WORD_PHASE
);
  import mro_pkg::*;

  typedef struct packed {
    logic              mclk_prev;
    logic              phase;
    logic              seq_rst;
    logic              strobe_n;
    logic [WORD_W-1:0] word;
    logic              drive;
    logic              taken;
  } mro_dev_state_t;

  mro_dev_state_t q;
  mro_dev_state_t d;

  logic [DEV_IN_W-1:0] pins_raw;
  logic [DEV_IN_W-1:0] pins_s;
  logic                s_mclk;
  logic                s_reset_n;
  logic                s_sync_n;
  logic                s_rd_wr_n;
  logic                s_cs_n;
  logic                s_f1;
  logic                s_f3;
  logic                s_clock_divider_select;
  logic [DEC_W-1:0]    s_dec;
  logic                mclk_rise;
  logic                mclk_fall;
  logic                mod_mode;
  logic [WORD_W-1:0]   code_ext;
  logic [WORD_W-1:0]   scaled;

  // Every link input is a pin, so all of it is synchronised
  assign pins_raw = {LINK.mclk, LINK.reset_n, LINK.sync_n, LINK.rd_wr_n, LINK.cs_n,
                     LINK.first_filter_bypass, LINK.third_filter_bypass,
                     LINK.clock_divider_select, LINK.decimation_select};

  mro_sync #(
    .W       (DEV_IN_W),
    .RST_VAL (DEV_IN_RST)
  ) u_pin_sync (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .i_d   (pins_raw),
    .o_q   (pins_s)
  );

  assign {s_mclk, s_reset_n, s_sync_n, s_rd_wr_n, s_cs_n, s_f1, s_f3, s_clock_divider_select, s_dec} = pins_s;

  // Master clock edges as one-cycle enables
  assign mclk_rise = s_mclk & ~q.mclk_prev;
  assign mclk_fall = ~s_mclk & q.mclk_prev;

  // All bypass and decimation bits zero selects raw output
  assign mod_mode = ~s_f1 & ~s_f3 & (s_dec == DEC_MOD_MODE);

  // Sign-extend to 16 bits, then force the four lowest bits to zero
  assign code_ext = {I_MOD_CODE[CODE_W-1], I_MOD_CODE};
  assign scaled   = {code_ext[WORD_W-1:ZERO_LSBS], {ZERO_LSBS{1'b0}}};

  always_comb begin
    d           = q;
    d.mclk_prev = s_mclk;
    d.taken     = 1'b0;
    if (!s_reset_n) begin
      // Pin reset clears the word phase; parity counts from its release
      d.phase    = 1'b0;
      d.seq_rst  = 1'b1;
      d.strobe_n = 1'b1;
      d.word     = '0;
    end else begin
      if (mclk_fall) begin
        d.seq_rst = ~s_sync_n;
        if (s_clock_divider_select) begin
          d.strobe_n = 1'b1;
        end
      end
      if (mclk_rise) begin
        // Phase keeps running through sync, which is why parity matters
        d.phase = ~q.phase;
        if (!mod_mode || q.seq_rst) begin
          // Filtered output is handled elsewhere; no words from here
          d.strobe_n = 1'b1;
        end else if (s_clock_divider_select) begin
          d.strobe_n = 1'b0;
          d.word     = scaled;
          d.taken    = 1'b1;
        end else begin
          d.strobe_n = ~q.phase;
          // Load only on a real rise, so data never moves under a high strobe
          if (!q.phase && !q.strobe_n) begin
            d.word  = scaled;
            d.taken = 1'b1;
          end
        end
      end
    end
    // Bus driven only while host holds both lines low
    d.drive = mod_mode & ~s_cs_n & ~s_rd_wr_n;
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q <= '{mclk_prev: 1'b0, phase: 1'b0, seq_rst: 1'b1, strobe_n: 1'b1,
             word: 16'h0000, drive: 1'b0, taken: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Link outputs
  assign LINK.word_ready_strobe_n = q.strobe_n;
  assign LINK.data_out            = q.word;
  assign LINK.data_oe_n           = ~q.drive;

  // Status outputs
  assign O_MOD_MODE          = mod_mode;
  assign O_SEQ_RESET         = q.seq_rst;
  assign O_CORRECTION_ENABLE = ~mod_mode;
  assign O_CODE_TAKEN        = q.taken;
  assign O_WORD_PHASE        = q.phase;
endmodule

// >>> verif/mro_properties.sv
// Concurrent checks on the pin-level link between converter and host ends
`timescale 1ns/1ps
module mro_properties #(
  parameter int unsigned MCLK_HALF = 4
) (
  // Clock and reset
  input  wire logic                        I_CLK,
  input  wire logic                        I_SYS_RST,
  // Host driven pins
  input  wire logic                        reset_n,
  input  wire logic                        sync_n,
  input  wire logic                        rd_wr_n,
  input  wire logic                        cs_n,
  input  wire logic                        first_filter_bypass,
  input  wire logic                        third_filter_bypass,
  input  wire logic                        clock_divider_select,
  input  wire logic [mro_pkg::DEC_W-1:0]   decimation_select,
  // Device driven pins
  input  wire logic                        word_ready_strobe_n,
  input  wire logic [mro_pkg::WORD_W-1:0]  data_out,
  input  wire logic                        data_oe_n
);
  logic [7:0] low_q;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  // Counts sync low time; repetition counts below assume MCLK_HALF of 4
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      low_q <= 8'h00;
    end else begin
      low_q <= sync_n ? 8'h00 : low_q + 8'h01;
    end
  end

  a_sync_low_len: assert property ($rose(sync_n) |-> low_q == 8'(8 * MCLK_HALF))
    else $error("sync low time wrong");
  // A pulse already started may run one more master clock period
  a_sync_holds_seq: assert property (low_q >= 8'(4 * MCLK_HALF) |-> word_ready_strobe_n)
    else $error("strobe while sync held");
  a_reset_pulse_len: assert property ($rose(reset_n) |-> !$past(reset_n, 8) && $past(reset_n, 9))
    else $error("reset pulse length wrong");
  // Twelve cycles: a half-rate pulse may run a full period after the mode drops
  a_idle_no_strobe: assert property (
    (first_filter_bypass || third_filter_bypass || decimation_select != 3'h0) [*8] ##1
    (first_filter_bypass || third_filter_bypass || decimation_select != 3'h0) [*4] |->
    word_ready_strobe_n)
    else $error("strobe outside raw mode");
  a_select_drives: assert property ($fell(data_oe_n) |-> !cs_n && !rd_wr_n)
    else $error("bus driven without select");
  a_release_bus: assert property ($rose(cs_n) |-> ##[1:4] data_oe_n)
    else $error("bus not released");
  a_low_nibble_zero: assert property (!data_oe_n |-> data_out[3:0] == 4'h0)
    else $error("low data bits not zero");
  a_full_rate_pulse: assert property (
    $fell(word_ready_strobe_n) && clock_divider_select |->
    !word_ready_strobe_n [*4] ##1 word_ready_strobe_n)
    else $error("full rate strobe wrong");
  a_half_rate_pulse: assert property (
    $fell(word_ready_strobe_n) && !clock_divider_select |->
    !word_ready_strobe_n [*8] ##1 word_ready_strobe_n [*8])
    else $error("half rate strobe wrong");
  a_full_data_stable: assert property (
    $rose(word_ready_strobe_n) && clock_divider_select |-> $stable(data_out))
    else $error("data moved at strobe rise");
  a_half_update_edge: assert property (
    !clock_divider_select && $changed(data_out) |-> $rose(word_ready_strobe_n))
    else $error("half rate data update off strobe rise");
endmodule

// >>> verif/mro_tb_top.sv
// Self-checking bench driving both ends of the raw modulator output link
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module mro_tb_top;
  import mro_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [3:0]         addr = 4'h0;
  logic [31:0]        wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        rdata;
  logic [15:0]        word;
  logic               word_valid;
  logic               par_odd;
  logic signed [14:0] code = 15'h0;
  logic               mod_mode;
  logic               seq_rst;
  logic               corr_en;
  logic               rn_q = 1'b1;
  logic               sn_q = 1'b1;
  logic               mk_q = 1'b0;
  logic               exp_odd = 1'b0;
  logic               e1;
  logic [31:0]        rv;
  logic               taken;
  logic               phase;
  int                 mcnt = 0;
  int                 nwords = 0;
  int                 ntk = 0;
  int                 n0 = 0;
  int                 k0 = 0;
  int                 cyc = 0;
  int                 errors = 0;
  int                 n_tests = 0;

  mro_link_if mro_link_if_i ();
  mro_device mro_device_i (.I_CLK(clk), .I_SYS_RST(rst), .LINK(mro_link_if_i),
    .I_MOD_CODE(code), .O_MOD_MODE(mod_mode), .O_SEQ_RESET(seq_rst),
    .O_CORRECTION_ENABLE(corr_en), .O_CODE_TAKEN(taken), .O_WORD_PHASE(phase));
  mro_host #(.MCLK_HALF(4), .LINK_DELAY(5)) mro_host_i (.I_CLK(clk), .I_SYS_RST(rst),
    .LINK(mro_link_if_i), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(reg_wr), .I_RD(reg_rd),
    .O_RDATA(rdata), .O_WORD(word), .O_WORD_VALID(word_valid), .O_PARITY_ODD(par_odd));
  mro_properties #(.MCLK_HALF(4)) mro_properties_i (.I_CLK(clk), .I_SYS_RST(rst),
    .reset_n(mro_link_if_i.reset_n), .sync_n(mro_link_if_i.sync_n),
    .rd_wr_n(mro_link_if_i.rd_wr_n), .cs_n(mro_link_if_i.cs_n),
    .first_filter_bypass(mro_link_if_i.first_filter_bypass),
    .third_filter_bypass(mro_link_if_i.third_filter_bypass),
    .clock_divider_select(mro_link_if_i.clock_divider_select),
    .decimation_select(mro_link_if_i.decimation_select),
    .word_ready_strobe_n(mro_link_if_i.word_ready_strobe_n),
    .data_out(mro_link_if_i.data_out), .data_oe_n(mro_link_if_i.data_oe_n));

  always #10 clk = ~clk;

  // Parity of master clock rises seen on the pins, reset release to sync release
  always @(posedge clk) begin
    rn_q <= mro_link_if_i.reset_n;
    sn_q <= mro_link_if_i.sync_n;
    mk_q <= mro_link_if_i.mclk;
    if (mro_link_if_i.reset_n && !rn_q) mcnt <= 0;
    else if (mro_link_if_i.mclk && !mk_q) mcnt <= mcnt + 1;
    if (mro_link_if_i.sync_n && !sn_q) exp_odd <= mcnt[0] ^ (mro_link_if_i.mclk && !mk_q);
    if (word_valid === 1'b1) nwords <= nwords + 1;
    if (taken === 1'b1) ntk <= ntk + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end

  task stop_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task bus_rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Device reset, a gap, then sync; pin-derived parity against the host's
  task t_seq(input int gap);
    bus_wr(REG_CMD, 32'h1);
    for (int i = 0; i < 100 && mro_link_if_i.reset_n !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK(phase, 1'b0)
    for (int i = 0; i < 100 && mro_link_if_i.reset_n !== 1'b1; i++) @(posedge clk);
    repeat (gap) @(posedge clk);
    bus_wr(REG_CMD, 32'h2);
    for (int i = 0; i < 100 && mro_link_if_i.sync_n !== 1'b0; i++) @(posedge clk);
    repeat (12) @(posedge clk);
    `CHK(seq_rst, 1'b1)
    for (int i = 0; i < 100 && mro_link_if_i.sync_n !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    `CHK(par_odd, exp_odd)
  endtask

  // Raw capture at a given rate, then stop and expect the bus released
  task t_capture(input logic [6:0] ctrl, input int lo, input int hi);
    logic [15:0] exp_w;
    exp_w = {code[14], code} & 16'hFFF0;
    bus_wr(REG_CTRL, {25'h0, ctrl});
    repeat (40) @(posedge clk);
    n0 = nwords;
    k0 = ntk;
    repeat (160) @(posedge clk);
    `CHK(nwords - n0 >= lo && nwords - n0 <= hi, 1'b1)
    `CHK(ntk - k0 >= lo && ntk - k0 <= hi, 1'b1)
    `CHK(word, exp_w)
    `CHK({mod_mode, corr_en}, 2'b10)
    bus_rd(REG_DATA, rv);
    `CHK(rv[15:0], exp_w)
    // Sync mid-capture with a new code: words stop, then resume with it
    code <= -code;
    bus_wr(REG_CMD, 32'h2);
    repeat (28) @(posedge clk);
    n0 = nwords;
    repeat (16) @(posedge clk);
    `CHK(nwords - n0, 0)
    repeat (48) @(posedge clk);
    exp_w = {code[14], code} & 16'hFFF0;
    `CHK(word, exp_w)
    bus_wr(REG_CTRL, {25'h0, ctrl & 7'h7E});
    repeat (8) @(posedge clk);
    `CHK(mro_link_if_i.data, 16'hFFFF)
  endtask

  // Select held but decimation select nonzero: no words, bus stays released
  task t_idle;
    bus_rd(REG_CTRL, rv);
    `CHK(rv[6:0], CTRL_RST)
    bus_rd(4'h2, rv);
    `CHK(rv, 32'h0)
    bus_wr(REG_CTRL, 32'h13);
    n0 = nwords;
    repeat (60) @(posedge clk);
    `CHK(nwords - n0, 0)
    `CHK(mro_link_if_i.data, 16'hFFFF)
    `CHK({mod_mode, corr_en}, 2'b01)
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_idle();
    do_reset();
    code <= 15'sd11620;
    t_seq(20);
    t_capture(7'h03, 19, 21);
    do_reset();
    code <= -15'sd11620;
    t_seq(20);
    e1 = exp_odd;
    t_capture(7'h01, 9, 11);
    do_reset();
    t_seq(28);
    `CHK(exp_odd, ~e1)
    t_capture(7'h01, 9, 11);
    stop_test();
  end
endmodule
